// ---- rtl/swdr_defs.svh ----
// Constants of the supervisor and watchdog block: offsets, fields, timing.
// Assumes a 10 MHz pclk; included by bare name.
`ifndef SWDR_DEFS_SVH
`define SWDR_DEFS_SVH

// ****************************************
// Widths and clock
// ****************************************
`define SWDR_CNT_W 24
`define SWDR_ADDR_W 8
`define SWDR_CLK_PERIOD_NS 100

// ****************************************
// Timing, in microseconds and in cycles
// ****************************************
`define SWDR_RST_DELAY_US 23000
`define SWDR_UPPER_US 855000
`define SWDR_LOWER_US 27600
// Least times round up, the longest time rounds down
`define SWDR_RST_DELAY_CYC \
  ((`SWDR_RST_DELAY_US * 1000 + `SWDR_CLK_PERIOD_NS - 1) / `SWDR_CLK_PERIOD_NS)
`define SWDR_UPPER_CYC ((`SWDR_UPPER_US * 1000) / `SWDR_CLK_PERIOD_NS)
`define SWDR_LOWER_CYC \
  ((`SWDR_LOWER_US * 1000 + `SWDR_CLK_PERIOD_NS - 1) / `SWDR_CLK_PERIOD_NS)

// ****************************************
// Register offsets
// ****************************************
`define SWDR_OFF_RST_DELAY 8'h00
`define SWDR_OFF_UPPER 8'h04
`define SWDR_OFF_LOWER 8'h08
`define SWDR_OFF_STATUS 8'h0C

// ****************************************
// Status fields
// ****************************************
`define SWDR_ST_RESET_N 0
`define SWDR_ST_FAULT_N 1
`define SWDR_ST_WD_LIVE 2
`define SWDR_ST_TIMEOUT 3
`define SWDR_ST_ARMED 4
`define SWDR_ST_STATE_LO 5
`define SWDR_ST_STATE_HI 7

`endif

// ---- rtl/swdr_pkg.sv ----
// Types of the supervisor and watchdog block.
// Assumes swdr_defs.svh for the counter width.
`include "swdr_defs.svh"

package swdr_pkg;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_POR_LOW = 3'b001,
    ST_POR_DELAY = 3'b010,
    ST_WATCH = 3'b011,
    ST_FAULT = 3'b100
  } swdr_state_t;

  typedef struct packed {
    logic [`SWDR_CNT_W-1:0] cnt;
  } swdr_timer_t;

  typedef struct packed {
    swdr_state_t st;
    logic rst_n;
    logic fault_n;
    logic armed;
    logic kick_prev;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [`SWDR_CNT_W-1:0] rst_delay;
    logic [`SWDR_CNT_W-1:0] upper;
    logic [`SWDR_CNT_W-1:0] lower;
  } swdr_top_t;

endpackage : swdr_pkg

// ---- rtl/swdr_sync.sv ----
// Two-stage synchroniser for a group of pin inputs.
// Assumes the pins are quasi-static against pclk.
`timescale 1ns/10ps

module swdr_sync #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } swdr_sync_t;

  swdr_sync_t sync_reg;
  swdr_sync_t sync_next;

  generate
    if (WIDTH < 1)
    begin : g_chk
      $error("swdr_sync: WIDTH must be at least 1");
    end
  endgenerate

  always_comb
  begin
    sync_next.s1 = din;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_reg <= '0;
    else
      sync_reg <= sync_next;
  end

  assign dout = sync_reg.s2;

endmodule : swdr_sync

// ---- rtl/swdr_timer.sv ----
// Saturating cycle counter with clear, run and a terminal count.
// Assumes clear wins over run; done is combinational on the count.
`timescale 1ns/10ps
`include "swdr_defs.svh"

module swdr_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clear,
  input wire logic run,
  input wire logic [`SWDR_CNT_W-1:0] limit,
  // Status
  output logic [`SWDR_CNT_W-1:0] count,
  output logic done
);

  swdr_pkg::swdr_timer_t tmr_reg;
  swdr_pkg::swdr_timer_t tmr_next;

  always_comb
  begin
    tmr_next = tmr_reg;
    if (clear)
      tmr_next.cnt = '0;
    else if (run && (tmr_reg.cnt != {`SWDR_CNT_W{1'b1}}))
      tmr_next.cnt = tmr_reg.cnt + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tmr_reg <= '0;
    else
      tmr_reg <= tmr_next;
  end

  assign count = tmr_reg.cnt;
  assign done = (tmr_reg.cnt >= limit);

endmodule : swdr_timer

// ---- rtl/swdr_top.sv ----
// Supervisor reset timer and processor watchdog, with APB registers.
// Assumes pins synchronous-safe via swdr_sync; vout_good from a comparator.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "swdr_defs.svh"

module swdr_top #(
  parameter int unsigned RST_DELAY_CYC = `SWDR_RST_DELAY_CYC,
  parameter int unsigned KICK_UPPER_CYC = `SWDR_UPPER_CYC,
  parameter int unsigned KICK_LOWER_CYC = `SWDR_LOWER_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SWDR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Supervisor pins
  input wire logic shutdown_input,
  input wire logic vout_good,
  output logic supervisor_reset_n,
  // Watchdog pins
  input wire logic watchdog_enable_n,
  input wire logic timeout_mode,
  input wire logic kick_input,
  output logic watchdog_fault_n
);

  localparam int CW = `SWDR_CNT_W;

  // ****************************************
  // Parameter checks
  // ****************************************
  generate
    if ((RST_DELAY_CYC < 1) || (RST_DELAY_CYC >= (1 << CW)) ||
        (KICK_UPPER_CYC < 1) || (KICK_UPPER_CYC >= (1 << CW)) ||
        (KICK_LOWER_CYC >= KICK_UPPER_CYC))
    begin : g_chk
      $error("swdr_top: counts must fit the counter and lower < upper");
    end
  endgenerate

  localparam swdr_pkg::swdr_top_t RESET_VAL = '{
    st: swdr_pkg::ST_OFF,
    rst_n: 1'b0,
    fault_n: 1'b1,
    armed: 1'b0,
    kick_prev: 1'b0,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0000_0000,
    rst_delay: CW'(RST_DELAY_CYC),
    upper: CW'(KICK_UPPER_CYC),
    lower: CW'(KICK_LOWER_CYC)
  };

  swdr_pkg::swdr_top_t top_reg;
  swdr_pkg::swdr_top_t top_next;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [4:0] pins_s;
  logic shut_s;
  logic vgood_s;
  logic en_n_s;
  logic timeout_s;
  logic kick_s;

  swdr_sync #(
    .WIDTH(5)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({kick_input, timeout_mode, watchdog_enable_n, vout_good, shutdown_input}),
    .dout(pins_s)
  );

  assign shut_s = pins_s[0];
  assign vgood_s = pins_s[1];
  assign en_n_s = pins_s[2];
  assign timeout_s = pins_s[3];
  assign kick_s = pins_s[4];

  // ****************************************
  // Kick edges
  // ****************************************
  logic kick_any;
  logic kick_fall;

  assign kick_any = kick_s ^ top_reg.kick_prev;
  assign kick_fall = top_reg.kick_prev & ~kick_s;

  // ****************************************
  // Timers
  // ****************************************
  logic rst_clr;
  logic rst_run;
  logic rst_done;
  logic wd_clr;
  logic wd_run;
  logic wd_done;
  logic [CW-1:0] wd_cnt;

  // One delay timer serves both power-on and fault pulse
  swdr_timer u_rst_timer (
    .pclk(pclk),
    .presetn(presetn),
    .clear(rst_clr),
    .run(rst_run),
    .limit(top_reg.rst_delay),
    .count(),
    .done(rst_done)
  );

  swdr_timer u_wd_timer (
    .pclk(pclk),
    .presetn(presetn),
    .clear(wd_clr),
    .run(wd_run),
    .limit(top_reg.upper),
    .count(wd_cnt),
    .done(wd_done)
  );

  // ****************************************
  // Register read mux
  // ****************************************
  logic [31:0] rd_data;
  logic addr_hit;

  always_comb
  begin
    rd_data = 32'h0000_0000;
    addr_hit = 1'b1;
    case (paddr)
      `SWDR_OFF_RST_DELAY: rd_data[CW-1:0] = top_reg.rst_delay;
      `SWDR_OFF_UPPER: rd_data[CW-1:0] = top_reg.upper;
      `SWDR_OFF_LOWER: rd_data[CW-1:0] = top_reg.lower;
      `SWDR_OFF_STATUS:
      begin
        rd_data[`SWDR_ST_RESET_N] = top_reg.rst_n;
        rd_data[`SWDR_ST_FAULT_N] = top_reg.fault_n;
        rd_data[`SWDR_ST_WD_LIVE] = (top_reg.st == swdr_pkg::ST_WATCH) & ~en_n_s;
        rd_data[`SWDR_ST_TIMEOUT] = timeout_s;
        rd_data[`SWDR_ST_ARMED] = top_reg.armed;
        rd_data[`SWDR_ST_STATE_HI:`SWDR_ST_STATE_LO] = top_reg.st;
      end
      default: addr_hit = 1'b0;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    top_next = top_reg;
    top_next.kick_prev = kick_s;
    rst_clr = 1'b0;
    rst_run = 1'b0;
    wd_clr = 1'b0;
    wd_run = 1'b0;

    // APB: one wait state, the write lands with pready high
    top_next.pready = psel & penable & ~top_reg.pready;
    if (psel && penable && !top_reg.pready)
    begin
      top_next.prdata = pwrite ? 32'h0000_0000 : rd_data;
      top_next.pslverr = ~addr_hit;
    end
    if (psel && penable && top_reg.pready && pwrite)
    begin
      case (paddr)
        `SWDR_OFF_RST_DELAY: top_next.rst_delay = pwdata[CW-1:0];
        `SWDR_OFF_UPPER: top_next.upper = pwdata[CW-1:0];
        `SWDR_OFF_LOWER: top_next.lower = pwdata[CW-1:0];
        default: top_next.rst_delay = top_reg.rst_delay;
      endcase
    end

    case (top_reg.st)
      swdr_pkg::ST_OFF:
      begin
        rst_clr = 1'b1;
        wd_clr = 1'b1;
        top_next.st = swdr_pkg::ST_POR_LOW;
      end
      swdr_pkg::ST_POR_LOW:
      begin
        rst_clr = 1'b1;
        wd_clr = 1'b1;
        top_next.rst_n = 1'b0;
        if (vgood_s)
          top_next.st = swdr_pkg::ST_POR_DELAY;
      end
      swdr_pkg::ST_POR_DELAY:
      begin
        rst_run = 1'b1;
        wd_clr = 1'b1;
        if (rst_done)
        begin
          top_next.rst_n = 1'b1;
          top_next.st = swdr_pkg::ST_WATCH;
          rst_clr = 1'b1;
        end
      end
      swdr_pkg::ST_WATCH:
      begin
        if (en_n_s)
        begin
          wd_clr = 1'b1;
          top_next.armed = 1'b0;
        end
        else if (timeout_s)
        begin
          if (kick_any)
            wd_clr = 1'b1;
          else if (wd_done)
            top_next.st = swdr_pkg::ST_FAULT;
          else
            wd_run = 1'b1;
        end
        else if (kick_fall)
        begin
          // First edge before arming has no previous edge to measure from
          if (top_reg.armed && (wd_cnt < top_reg.lower))
            top_next.st = swdr_pkg::ST_FAULT;
          else
          begin
            wd_clr = 1'b1;
            top_next.armed = 1'b1;
          end
        end
        else if (wd_done)
          top_next.st = swdr_pkg::ST_FAULT;
        else
          wd_run = 1'b1;
        if (top_next.st == swdr_pkg::ST_FAULT)
        begin
          top_next.fault_n = 1'b0;
          top_next.armed = 1'b0;
          rst_clr = 1'b1;
          wd_clr = 1'b1;
        end
      end
      swdr_pkg::ST_FAULT:
      begin
        wd_clr = 1'b1;
        rst_run = 1'b1;
        if (rst_done || en_n_s)
        begin
          top_next.fault_n = 1'b1;
          top_next.st = swdr_pkg::ST_WATCH;
          rst_clr = 1'b1;
        end
      end
      default:
      begin
        top_next.st = swdr_pkg::ST_OFF;
      end
    endcase

    // Voltage drop overrides the whole state machine except shutdown; register writes still land
    if (!vgood_s && (top_reg.st != swdr_pkg::ST_OFF))
    begin
      top_next.st = swdr_pkg::ST_POR_LOW;
      top_next.rst_n = 1'b0;
      top_next.fault_n = 1'b1;
      top_next.armed = 1'b0;
      rst_clr = 1'b1;
      rst_run = 1'b0;
      wd_clr = 1'b1;
      wd_run = 1'b0;
    end
    if (!shut_s)
    begin
      top_next.st = swdr_pkg::ST_OFF;
      top_next.rst_n = 1'b0;
      top_next.fault_n = 1'b1;
      top_next.armed = 1'b0;
      rst_clr = 1'b1;
      rst_run = 1'b0;
      wd_clr = 1'b1;
      wd_run = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      top_reg <= RESET_VAL;
    else
      top_reg <= top_next;
  end

  assign prdata = top_reg.prdata;
  assign pready = top_reg.pready;
  assign pslverr = top_reg.pslverr;
  assign supervisor_reset_n = top_reg.rst_n;
  assign watchdog_fault_n = top_reg.fault_n;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_live;
    shut_s && vgood_s && (top_reg.st == swdr_pkg::ST_WATCH) && !en_n_s;
  endsequence

  sequence s_early_fall;
    s_live ##0 (!timeout_s && kick_fall && top_reg.armed && (wd_cnt < top_reg.lower));
  endsequence

  sequence s_upper_miss;
    s_live ##0 (wd_done && !kick_any);
  endsequence

  a_vout_low_reset: assert property (shut_s && !vgood_s |=> !supervisor_reset_n)
    else $error("reset not held low on low output voltage");

  a_reset_release: assert property ($rose(supervisor_reset_n) |->
    $past(rst_done) && ($past(top_reg.st) == swdr_pkg::ST_POR_DELAY))
    else $error("reset released before delay expired");

  a_shutdown_idle: assert property (!shut_s |=> !supervisor_reset_n &&
    watchdog_fault_n && (wd_cnt == '0))
    else $error("logic active during shutdown");

  a_disabled_idle: assert property (en_n_s ##1 en_n_s |-> watchdog_fault_n &&
    (wd_cnt == '0))
    else $error("watchdog active while disabled");

  a_timeout_clear: assert property (s_live ##0 (timeout_s && kick_any) |=>
    (wd_cnt == '0) && watchdog_fault_n)
    else $error("kick did not clear timer");

  a_window_early: assert property (s_early_fall |=> !watchdog_fault_n)
    else $error("early falling edge not faulted");

  a_upper_miss: assert property (s_upper_miss |=> !watchdog_fault_n)
    else $error("missed kick not faulted");

  a_fault_hold: assert property (!watchdog_fault_n && shut_s && vgood_s &&
    !rst_done && !en_n_s |=> !watchdog_fault_n)
    else $error("fault released early");

  a_fault_end: assert property (!watchdog_fault_n && (rst_done || !vgood_s) |=>
    watchdog_fault_n)
    else $error("fault not returned high");

  a_kick_ignored: assert property (top_reg.st == swdr_pkg::ST_FAULT |->
    (wd_cnt == '0) ##1 (wd_cnt == '0))
    else $error("watchdog timer ran during fault");

  a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one wait state");

endmodule : swdr_top

// ---- verif/supervisor_watchdog_reset_bench.sv ----
// Self-checking bench of the supervisor and watchdog block.
// Assumes swdr_top with shortened counts and the processor model beside it.
`timescale 1ns/10ps

module supervisor_watchdog_reset_bench;
  localparam int RST = 20;
  localparam int UPR = 200;
  localparam int LWR = 50;
  typedef struct {
    logic wr;
    logic [7:0] a;
    logic [31:0] wd;
    logic [31:0] exp;
    logic err;
  } swdr_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, run;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic shutdown_input, vout_good, supervisor_reset_n;
  logic watchdog_enable_n, timeout_mode, kick_input, watchdog_fault_n;
  logic [15:0] half_cycles;
  int miscompares, num_checks, n;
  // Register accesses while shut down; status reads show off state, timeout pin high, fault high
  swdr_row_t rows [13] = '{
    '{1'b0, 8'h00, 32'h0, 32'(RST), 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'(UPR), 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'(LWR), 1'b0},
    '{1'b0, 8'h10, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h08, 32'hFF000031, 32'h0, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'h00000031, 1'b0},
    '{1'b1, 8'h20, 32'h5, 32'h0, 1'b1},
    '{1'b1, 8'h04, 32'h0000012C, 32'h0, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'h0000012C, 1'b0},
    '{1'b1, 8'h04, 32'(UPR), 32'h0, 1'b0},
    '{1'b0, 8'h0C, 32'h0, 32'h0000000A, 1'b0},
    '{1'b1, 8'h0C, 32'hFFFFFFFF, 32'h0, 1'b0},
    '{1'b0, 8'h0C, 32'h0, 32'h0000000A, 1'b0}};

  swdr_top #(.RST_DELAY_CYC(RST), .KICK_UPPER_CYC(UPR), .KICK_LOWER_CYC(LWR)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shutdown_input(shutdown_input), .vout_good(vout_good),
    .supervisor_reset_n(supervisor_reset_n), .watchdog_enable_n(watchdog_enable_n),
    .timeout_mode(timeout_mode), .kick_input(kick_input),
    .watchdog_fault_n(watchdog_fault_n));

  swdr_cpu_model cpu (.pclk(pclk), .run(run), .half_cycles(half_cycles),
    .kick_input(kick_input));

  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  // ****************************************
  // Checks and bus cycles
  // ****************************************
  task automatic tally_and_finish;
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_range(input int v, input int lo, input int hi);
    num_checks++;
    if (v < lo || v > hi)
    begin
      miscompares++;
      $display("ERROR %0t delay %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask : chk_range

  function automatic logic sig(input int which);
    return which == 1 ? watchdog_fault_n : supervisor_reset_n;
  endfunction : sig

  task automatic wait_for(input int which, input logic lvl, input int max);
    n = 0;
    while (sig(which) !== lvl && n < max)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (sig(which) !== lvl)
    begin
      miscompares++;
      $display("ERROR %0t output %0d never reached its level", $time, which);
      tally_and_finish();
    end
  endtask : wait_for

  task automatic hold(input int which, input logic lvl, input int cyc);
    int bad;
    bad = 0;
    repeat (cyc)
    begin
      @(posedge pclk);
      #1;
      if (sig(which) !== lvl)
        bad++;
    end
    chk(32'(bad), 32'h0);
  endtask : hold

  // Request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      miscompares++;
      $display("ERROR %0t bus transfer never answered", $time);
      tally_and_finish();
    end
  endtask : apb

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {shutdown_input, vout_good, watchdog_enable_n, timeout_mode, run} = 5'h0F;
    half_cycles = 16'h0064;
    miscompares = 0;
    num_checks = 0;
    repeat (4) @(posedge pclk);
    #1 chk(32'(supervisor_reset_n), 32'h0);
    chk(32'(watchdog_fault_n), 32'h1);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].wr, rows[i].a, rows[i].wd);
      chk(rd, rows[i].exp);
      chk(32'(er), 32'(rows[i].err));
    end
    hold(0, 1'b0, 2 * RST);
    @(posedge pclk);
    vout_good <= 1'b0;
    shutdown_input <= 1'b1;
    hold(0, 1'b0, 2 * RST);
    @(posedge pclk);
    vout_good <= 1'b1;
    wait_for(0, 1'b1, RST + 12);
    chk_range(n, RST, RST + 8);
    // Disabled watchdog outlives the upper limit while the model still kicks
    hold(1, 1'b1, 300);
    @(posedge pclk);
    watchdog_enable_n <= 1'b0;
    run <= 1'b1;
    hold(1, 1'b1, 600);
    @(posedge pclk);
    run <= 1'b0;
    wait_for(1, 1'b0, UPR + 20);
    chk_range(n, UPR - 100, UPR + 6);
    wait_for(1, 1'b1, RST + 12);
    chk_range(n, RST, RST + 4);
    @(posedge pclk);
    timeout_mode <= 1'b0;
    half_cycles <= 16'h0028;
    run <= 1'b1;
    hold(1, 1'b1, 600);
    @(posedge pclk);
    half_cycles <= 16'h000A;
    wait_for(1, 1'b0, 100);
    chk_range(n, 0, 60);
    // Fast kicks go on during the pulse and must not stretch it
    wait_for(1, 1'b1, RST + 12);
    chk_range(n, RST, RST + 4);
    @(posedge pclk);
    half_cycles <= 16'h0096;
    wait_for(1, 1'b0, 400);
    chk_range(n, UPR, 360);
    repeat (3) @(posedge pclk);
    vout_good <= 1'b0;
    run <= 1'b0;
    wait_for(1, 1'b1, 6);
    chk_range(n, 1, 5);
    wait_for(0, 1'b0, 6);
    chk_range(n, 0, 5);
    apb(1'b1, 8'h00, 32'h00000028);
    chk(32'(er), 32'h0);
    @(posedge pclk);
    vout_good <= 1'b1;
    wait_for(0, 1'b1, 60);
    chk_range(n, 40, 48);
    @(posedge pclk);
    shutdown_input <= 1'b0;
    wait_for(0, 1'b0, 6);
    chk_range(n, 1, 5);
    hold(1, 1'b1, 10);
    tally_and_finish();
  end
endmodule : supervisor_watchdog_reset_bench

// ---- verif/swdr_cpu_model.sv ----
// Processor model: drives the kick pin of the watchdog with a steady toggle.
// Assumes the bench sets the half period and starts or stops the kicking.
`timescale 1ns/10ps

module swdr_cpu_model (
  // Clock
  input wire logic pclk,
  // Control from the bench
  input wire logic run,
  input wire logic [15:0] half_cycles,
  // Pin to the watchdog
  output logic kick_input
);
  int cnt;

  initial kick_input = 1'b1;
  initial cnt = 0;

  // Push-pull pin: a stopped processor holds its last level
  always @(posedge pclk)
  begin
    if (!run)
      cnt <= 0;
    else if (cnt >= int'(half_cycles) - 1)
    begin
      cnt <= 0;
      kick_input <= ~kick_input;
    end
    else
      cnt <= cnt + 1;
  end
endmodule : swdr_cpu_model
